// *** design/ffc_top.sv ***
/*
  Fault status, mask foldback and auxiliary mode registers of the flash
  driver, reached over the serial register port. Assumes the analog side
  delivers fault events as level pins and the mode, output enable and pin
  configuration bits come from neighbouring registers on the same clock.
*/
`timescale 1ns/100ps
`include "ffc_regs.svh"
module ffc_top #(
  parameter logic [6:0] DEV_ADDR = 7'h30  // Arbitrary bus address
) (
  input wire logic core_clk,                    // 10 MHz system clock
  input wire logic rstn,                        // Synchronous reset, active low
  input wire logic scl_pin,                     // Serial clock pin
  input wire logic sda_in,                      // Serial data pin level
  output logic sda_out,                         // Serial data drive value, always low
  output logic sda_oe,                          // Serial data pull-low enable
  input wire logic strobe_pin,                  // Flash strobe pin
  input wire logic transmit_mask_one,           // First transmit mask pin
  input wire logic general_pin_two,             // Pin two, mask two when so configured
  input wire logic ovp_event,                   // Overvoltage detected
  input wire logic sc_event,                    // Short circuit detected
  input wire logic ot_event,                    // Over-temperature detected
  input wire logic timeout_event,               // Flash timer expired
  input wire logic indicator_led_output_fault_event,            // Indicator LED fault detected
  input wire logic inductor_limit_event,        // Inductor peak limit hit
  input wire logic input_limit_event,           // Input dc limit reached
  input wire logic hw_strobe_mode,              // 1 hardware strobe, 0 software
  input wire logic output_enable,               // Output on
  input wire logic flash_mode_sel,              // LED mode is flash
  input wire logic pin2_is_mask2,               // 1 pin two is mask two, 0 indicator output
  output logic dynamic_overvoltage_enable,      // Dynamic overvoltage protection on
  output logic force_low_frequency,             // Force 1.5 MHz switching
  output logic strobe_polarity,                 // 1 strobe active high
  output logic [1:0] indicator_current_code,    // Indicator LED current
  output logic [1:0] input_limit_level,         // Input dc limit level
  output logic input_limit_enable,              // Input dc limit on
  output logic [3:0] mask1_foldback_code,       // Mask one foldback current
  output logic [3:0] mask2_foldback_code,       // Mask two foldback current
  output logic flash_active,                    // Flash in progress
  output logic mask1_foldback_active,           // Flash folded back by mask one
  output logic mask2_foldback_active            // Flash folded back by mask two
);
  import ffc_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic [11:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic strobe_s;
  logic mask1_s;
  logic pin2_s;
  logic [5:0] hw_evt;
  logic indicator_led_output_s;

  ffc_sync #(.WIDTH(12)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .async_in({scl_pin, sda_in, strobe_pin, transmit_mask_one, general_pin_two, indicator_led_output_fault_event,
               ovp_event, sc_event, ot_event, timeout_event, inductor_limit_event, input_limit_event}),
    .sync_out(pins_s)
  );

  assign scl_s = pins_s[11];
  assign sda_s = pins_s[10];
  assign strobe_s = pins_s[9];
  assign mask1_s = pins_s[8];
  assign pin2_s = pins_s[7];
  assign indicator_led_output_s = pins_s[6];
  assign hw_evt = pins_s[5:0];

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  ffc_byte_t reg_addr;
  ffc_byte_t reg_wdata;
  ffc_byte_t reg_rdata;
  logic reg_wr;
  logic reg_rd;

  ffc_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
    .core_clk(core_clk),
    .rstn(rstn),
    .scl(scl_s),
    .sda(sda_s),
    .sda_oe(sda_oe),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // Open drain: the pin only ever pulls low
  always_ff @(posedge core_clk) begin
    sda_out <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------------
  logic fold_wr;
  logic mode_wr;
  logic fault_rd;

  assign fold_wr = reg_wr && reg_addr == `FFC_FOLD_OFS;
  assign mode_wr = reg_wr && reg_addr == `FFC_MODE_OFS;
  assign fault_rd = reg_rd && reg_addr == `FFC_FAULT_OFS;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {mask2_foldback_code, mask1_foldback_code} <= `FFC_FOLD_RST;
    end else if (fold_wr) begin
      mask2_foldback_code <= reg_wdata[`FFC_FOLD_M2_LSB +: 4];
      mask1_foldback_code <= reg_wdata[`FFC_FOLD_M1_LSB +: 4];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      {dynamic_overvoltage_enable, force_low_frequency, strobe_polarity, indicator_current_code,
       input_limit_level, input_limit_enable} <= `FFC_MODE_RST;
    end else if (mode_wr) begin
      dynamic_overvoltage_enable <= reg_wdata[`FFC_MODE_DYN_BIT];
      force_low_frequency <= reg_wdata[`FFC_MODE_FLO_BIT];
      strobe_polarity <= reg_wdata[`FFC_MODE_POL_BIT];
      indicator_current_code <= reg_wdata[`FFC_MODE_INDICATOR_LED_OUTPUT_LSB +: 2];
      input_limit_level <= reg_wdata[`FFC_MODE_ILIM_LSB +: 2];
      input_limit_enable <= reg_wdata[`FFC_MODE_ILEN_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Flash sequencing
  // ----------------------------------------------------------------------
  logic strobe_act;
  logic next_flash;
  logic flash_start;

  assign strobe_act = strobe_polarity ? strobe_s : ~strobe_s;
  assign next_flash = output_enable & flash_mode_sel & (~hw_strobe_mode | strobe_act);
  assign flash_start = next_flash & ~flash_active;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flash_active <= 1'b0;
      mask1_foldback_active <= 1'b0;
      mask2_foldback_active <= 1'b0;
    end else begin
      flash_active <= next_flash;
      mask1_foldback_active <= next_flash & mask1_s;
      mask2_foldback_active <= next_flash & pin2_is_mask2 & pin2_s;
    end
  end

  // ----------------------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------------------
  // Order: overvoltage, short, over-temperature, timeout, inductor, input dc
  logic [5:0] hw_flag;
  logic [5:0] hw_set;
  logic mask1_flag;
  logic mask2_flag;
  logic indicator_led_output_flag;
  logic pin2_flag;

  // Input dc limit only counts while the limit is enabled
  assign hw_set = {hw_evt[5:1], hw_evt[0] & input_limit_enable};

  // Cleared by reading the register; an event in the read cycle still lands
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hw_flag <= 6'h00;
    end else begin
      hw_flag <= (hw_flag & ~{6{fault_rd}}) | hw_set;
    end
  end

  // Mask flags describe the latest flash only, so a new flash wipes them
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mask1_flag <= 1'b0;
      mask2_flag <= 1'b0;
    end else begin
      mask1_flag <= (mask1_flag & ~flash_start) | (next_flash & mask1_s);
      mask2_flag <= (mask2_flag & ~flash_start) | (next_flash & pin2_is_mask2 & pin2_s);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      indicator_led_output_flag <= 1'b0;
    end else begin
      indicator_led_output_flag <= (indicator_led_output_flag & ~fault_rd) | (indicator_led_output_s & ~pin2_is_mask2);
    end
  end

  assign pin2_flag = pin2_is_mask2 ? mask2_flag : indicator_led_output_flag;

  // ----------------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------------
  // One place fixes the mode bit order for the read path and the checks
  function automatic ffc_byte_t mode_image(input logic dyn, input logic flo, input logic pol,
    input logic [1:0] indicator_led_output, input logic [1:0] ilim, input logic ilen);
    return {dyn, flo, pol, indicator_led_output, ilim, ilen};
  endfunction

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  always_comb begin
    case (reg_addr)
      `FFC_FAULT_OFS: reg_rdata = {hw_flag[5:2], mask1_flag, pin2_flag, hw_flag[1:0]};
      `FFC_FOLD_OFS: reg_rdata = {mask2_foldback_code, mask1_foldback_code};
      `FFC_MODE_OFS: reg_rdata = mode_image(dynamic_overvoltage_enable, force_low_frequency, strobe_polarity,
        indicator_current_code, input_limit_level, input_limit_enable);
      default: reg_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_ovp_flag_set: assert property (hw_evt[5] |=> reg_rdata[7] || reg_addr != `FFC_FAULT_OFS)
    else $error("overvoltage event not latched");

  a_flags_hold: assert property (!fault_rd |=> (hw_flag & $past(hw_flag)) == $past(hw_flag))
    else $error("fault flag dropped without a read");

  a_mask1_flag_set: assert property (next_flash && mask1_s |=> mask1_flag ##0 flash_active)
    else $error("mask one action not recorded");

  a_flash_clears_flags: assert property (flash_start && !mask1_s && !pin2_s |=> !mask1_flag && !mask2_flag)
    else $error("mask flags survived a new flash");

  a_pin2_mask_read: assert property (mask2_flag && pin2_is_mask2 && reg_addr == `FFC_FAULT_OFS |-> reg_rdata[2])
    else $error("fault bit 2 lost mask two action");

  a_pin2_indicator_led_output_read: assert property (indicator_led_output_flag && !pin2_is_mask2 && reg_addr == `FFC_FAULT_OFS |-> reg_rdata[2])
    else $error("fault bit 2 lost indicator fault");

  a_indicator_led_output_flag_set: assert property (indicator_led_output_s && !pin2_is_mask2 |=> indicator_led_output_flag)
    else $error("indicator fault not latched");

  a_inductor_flag: assert property (hw_evt[1] |=> hw_flag[1] ##1 (hw_flag[1] || $past(fault_rd)))
    else $error("inductor limit flag not held");

  a_input_limit_flag: assert property (hw_evt[0] && input_limit_enable |=> hw_flag[0])
    else $error("input limit flag not latched");

  a_input_limit_off: assert property (!hw_flag[0] && !(hw_evt[0] && input_limit_enable) |=> !hw_flag[0])
    else $error("input limit flag set while disabled");

  a_fold_write: assert property (fold_wr |=> {mask2_foldback_code, mask1_foldback_code} == $past(reg_wdata))
    else $error("foldback register write lost");

  a_mode_write: assert property (mode_wr |=> mode_image(dynamic_overvoltage_enable, force_low_frequency,
    strobe_polarity, indicator_current_code, input_limit_level, input_limit_enable) == $past(reg_wdata))
    else $error("mode register write lost");

  a_hw_strobe_gate: assert property (hw_strobe_mode && (strobe_s != strobe_polarity) |=> !flash_active)
    else $error("flash without strobe in hardware mode");

  a_sw_strobe_go: assert property (!hw_strobe_mode && output_enable && flash_mode_sel |=> flash_active)
    else $error("software flash did not start");

  a_read_clears: assert property (fault_rd && hw_set == 6'h00 |=> hw_flag == 6'h00)
    else $error("fault flags not cleared by read");

  a_timeout_flag: assert property (hw_evt[2] |=> hw_flag[2])
    else $error("timeout flag not latched");

  a_fold_hold: assert property (!fold_wr |=> $stable({mask2_foldback_code, mask1_foldback_code}))
    else $error("foldback register changed without a write");

  a_mode_hold: assert property (!mode_wr |=>
    $stable({force_low_frequency, indicator_current_code, input_limit_level}))
    else $error("mode register changed without a write");

  a_oe_gate: assert property (!output_enable |=> !flash_active)
    else $error("flash while output disabled");

  a_flash_mode_gate: assert property (!flash_mode_sel |=> !flash_active)
    else $error("flash outside flash mode");

  a_mask1_active: assert property (next_flash && mask1_s |=> mask1_foldback_active)
    else $error("mask one foldback not shown");

  a_mask2_active: assert property (next_flash && pin2_is_mask2 && pin2_s |=> mask2_foldback_active)
    else $error("mask two foldback not shown");

  a_mask2_gate: assert property (!pin2_is_mask2 |=> !mask2_foldback_active)
    else $error("mask two foldback with pin two as indicator");

  a_mask2_flag_set: assert property (next_flash && pin2_is_mask2 && pin2_s |=> mask2_flag)
    else $error("mask two action not recorded");

  a_indicator_led_output_ignored: assert property (pin2_is_mask2 && !indicator_led_output_flag |=> !indicator_led_output_flag)
    else $error("indicator fault latched in mask mode");

  a_mask1_flag_hold: assert property (!flash_start |=> mask1_flag || !$past(mask1_flag))
    else $error("mask one flag dropped inside a flash");

endmodule

// *** design/ffc_regs.svh ***
/*
  Offsets, field positions and reset values of the flash fault and input
  control register bank. Assumes inclusion by bare name from design files.
*/
`ifndef FFC_REGS_SVH
`define FFC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FFC_FAULT_OFS 8'h05
`define FFC_FOLD_OFS 8'h06
`define FFC_MODE_OFS 8'h07

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FFC_FOLD_RST 8'h66
`define FFC_MODE_RST 8'h24

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FFC_FAULT_MASK1_BIT 3
`define FFC_FAULT_PIN2_BIT 2
`define FFC_FOLD_M2_LSB 4
`define FFC_FOLD_M1_LSB 0
`define FFC_MODE_DYN_BIT 7
`define FFC_MODE_FLO_BIT 6
`define FFC_MODE_POL_BIT 5
`define FFC_MODE_INDICATOR_LED_OUTPUT_LSB 3
`define FFC_MODE_ILIM_LSB 1
`define FFC_MODE_ILEN_BIT 0

`endif

// *** design/ffc_pkg.sv ***
/*
  Types shared by the flash fault and input control block.
  Assumes the constants header is compiled alongside.
*/
package ffc_pkg;

  typedef logic [7:0] ffc_byte_t;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ADDR  = 8'h02,
    ST_ACK_A = 8'h04,
    ST_REG   = 8'h08,
    ST_ACK_R = 8'h10,
    ST_WDATA = 8'h20,
    ST_RDATA = 8'h40,
    ST_MACK  = 8'h80
  } ffc_i2c_state_t;

endpackage

// *** design/ffc_sync.sv ***
/*
  Three-stage synchroniser for pin inputs; the output follows once the
  second and third stages agree. Assumes one clock, synchronous reset.
*/
`timescale 1ns/100ps
module ffc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,              // System clock
  input wire logic rstn,                  // Synchronous reset, active low
  input wire logic [WIDTH-1:0] async_in,  // Raw pin levels
  output logic [WIDTH-1:0] sync_out       // Filtered, synchronised levels
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Only a level seen by two later stages moves the output
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sync_out <= '0;
    end else begin
      sync_out <= (s2 & s3) | (sync_out & (s2 | s3));
    end
  end

endmodule

// *** design/ffc_i2c_slave.sv ***
/*
  Serial register port slave: 7-bit device address, register pointer byte,
  auto-incrementing writes and reads. Assumes scl and sda already
  synchronised; sda is open drain, driven low while sda_oe is high.
*/
`timescale 1ns/100ps
module ffc_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h30  // Arbitrary bus address
) (
  input wire logic core_clk,                 // System clock
  input wire logic rstn,                     // Synchronous reset, active low
  input wire logic scl,                      // Synchronised clock line
  input wire logic sda,                      // Synchronised data line
  output logic sda_oe,                       // Pull data line low
  output ffc_pkg::ffc_byte_t reg_addr,       // Register pointer
  output ffc_pkg::ffc_byte_t reg_wdata,      // Write data
  output logic reg_wr,                       // Write strobe, one cycle
  output logic reg_rd,                       // Read strobe, one cycle
  input wire ffc_pkg::ffc_byte_t reg_rdata   // Read data at reg_addr
);
  import ffc_pkg::*;

  ffc_i2c_state_t state;
  logic scl_d;
  logic sda_d;
  logic [3:0] cnt;
  ffc_byte_t shreg;
  logic rw;
  logic nack;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start_c = scl & scl_d & sda_d & ~sda;
  assign stop_c = scl & scl_d & ~sda_d & sda;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // Pointer moves on after every register access
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      reg_addr <= 8'h00;
    end else if (state == ST_ACK_R && scl_fall && !reg_wr && cnt == 4'h0 && !rw && shreg == reg_addr) begin
      reg_addr <= reg_addr;
    end else if (reg_wr || reg_rd) begin
      reg_addr <= reg_addr + 8'h01;
    end else if (state == ST_REG && scl_fall && cnt == 4'h8) begin
      reg_addr <= shreg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      if (start_c) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              cnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shreg[7:1] == DEV_ADDR) begin
                  rw <= shreg[0];
                  sda_oe <= 1'b1;
                  state <= ST_ACK_A;
                end else begin
                  state <= ST_IDLE;
                end
              end else if (state == ST_REG) begin
                sda_oe <= 1'b1;
                state <= ST_ACK_R;
              end else begin
                reg_wdata <= shreg;
                reg_wr <= 1'b1;
                sda_oe <= 1'b1;
                state <= ST_ACK_R;
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              cnt <= 4'h0;
              if (rw) begin
                reg_rd <= 1'b1;
                state <= ST_RDATA;
              end else begin
                state <= ST_REG;
              end
            end
          end
          ST_ACK_R: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            // Byte is captured in the strobe cycle so the block sees the same value
            if (reg_rd) begin
              shreg <= reg_rdata;
              sda_oe <= ~reg_rdata[7];
            end else if (scl_fall) begin
              if (cnt == 4'h7) begin
                sda_oe <= 1'b0;
                state <= ST_MACK;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
                cnt <= cnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              nack <= sda;
            end else if (scl_fall) begin
              cnt <= 4'h0;
              if (nack) begin
                state <= ST_IDLE;
              end else begin
                reg_rd <= 1'b1;
                state <= ST_RDATA;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// *** tb/ffc_host.sv ***
/*
  Host model for the flash register port: bus master with start, stop and
  byte transfer tasks. Assumes the bench resolves the open-drain data line.
*/
`timescale 1ns/100ps
module ffc_host (
  input wire logic core_clk, // System clock
  input wire logic sda,      // Resolved data line level
  output logic scl,          // Serial clock, idles high
  output logic sda_low       // Pull data line low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Half periods of 10 clocks keep above the 8-clock minimum
  task automatic start();
    sda_low <= 1'b0;
    wt(10);
    scl <= 1'b1;
    wt(10);
    sda_low <= 1'b1;
    wt(10);
    scl <= 1'b0;
    wt(5);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    wt(10);
    scl <= 1'b1;
    wt(10);
    sda_low <= 1'b0;
    wt(10);
  endtask
  // Data moves 5 clocks after scl falls, clear of the slave's own sampling
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
    logic [8:0] w;
    logic [8:0] g;
    w = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_low <= ~w[i];
      wt(10);
      scl <= 1'b1;
      wt(10);
      g[i] = sda;
      scl <= 1'b0;
      wt(5);
    end
    r = g[8:1];
    ack = ~g[0];
  endtask
endmodule

// *** tb/tb_ffc_top.sv ***
/*
  Self-checking bench for the flash fault and input control registers.
  Assumes the host model and the design files are compiled before it.
*/
`timescale 1ns/100ps
`include "ffc_regs.svh"
module tb_ffc_top;
  localparam logic [6:0] DEV = 7'h30;
  logic core_clk = 1'b0;
  logic rstn, strobe_pin, tm1, gp2, hw, oe, fms, p2m;
  logic ovp_ev, sc_ev, ot_ev, to_ev, indicator_led_output_ev, il_ev, idc_ev;
  logic dyn, flo, pol, ilen, fa, m1a, m2a, sda_out, sda_oe, scl, host_low, sda_line;
  logic [1:0] indicator_led_output, ilim;
  logic [3:0] m1c, m2c;
  logic [7:0] rd;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_low;
  always #50 core_clk = ~core_clk;
  ffc_host host_u (.core_clk(core_clk), .sda(sda_line), .scl(scl), .sda_low(host_low));
  ffc_top dut_u (.core_clk(core_clk), .rstn(rstn), .scl_pin(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .strobe_pin(strobe_pin), .transmit_mask_one(tm1),
    .general_pin_two(gp2), .ovp_event(ovp_ev), .sc_event(sc_ev), .ot_event(ot_ev),
    .timeout_event(to_ev), .indicator_led_output_fault_event(indicator_led_output_ev), .inductor_limit_event(il_ev),
    .input_limit_event(idc_ev), .hw_strobe_mode(hw), .output_enable(oe), .flash_mode_sel(fms),
    .pin2_is_mask2(p2m), .dynamic_overvoltage_enable(dyn), .force_low_frequency(flo),
    .strobe_polarity(pol), .indicator_current_code(indicator_led_output), .input_limit_level(ilim),
    .input_limit_enable(ilen), .mask1_foldback_code(m1c), .mask2_foldback_code(m2c),
    .flash_active(fa), .mask1_foldback_active(m1a), .mask2_foldback_active(m2a));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic k;
    host_u.start();
    host_u.xfer({DEV, 1'b0}, 1'b1, r, k);
    chk("write ack", 8'h01, {7'h00, k});
    host_u.xfer(a, 1'b1, r, k);
    host_u.xfer(d, 1'b1, r, k);
    host_u.stop();
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    logic k;
    host_u.start();
    host_u.xfer({DEV, 1'b0}, 1'b1, r, k);
    host_u.xfer(a, 1'b1, r, k);
    host_u.start();
    host_u.xfer({DEV, 1'b1}, 1'b1, r, k);
    chk("read ack", 8'h01, {7'h00, k});
    host_u.xfer(8'hff, 1'b1, r, k);
    host_u.stop();
    chk("register", e, r);
  endtask
  task automatic pulse(input logic [6:0] x);
    {ovp_ev, sc_ev, ot_ev, to_ev, indicator_led_output_ev, il_ev, idc_ev} <= x;
    host_u.wt(8);
    {ovp_ev, sc_ev, ot_ev, to_ev, indicator_led_output_ev, il_ev, idc_ev} <= 7'h00;
    host_u.wt(8);
  endtask
  // Hang guard: the whole run needs roughly 27000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      test_done();
    end
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    {rstn, strobe_pin, tm1, gp2, hw, oe, fms, p2m} <= 8'h00;
    {ovp_ev, sc_ev, ot_ev, to_ev, indicator_led_output_ev, il_ev, idc_ev} <= 7'h00;
    host_u.wt(3);
    chk("mode ports", `FFC_MODE_RST, {dyn, flo, pol, indicator_led_output, ilim, ilen});
    chk("fold ports", `FFC_FOLD_RST, {m2c, m1c});
    rstn <= 1'b1;
    host_u.wt(10);
    rd_reg(`FFC_FAULT_OFS, 8'h00);
    rd_reg(`FFC_FOLD_OFS, 8'h66);
    rd_reg(`FFC_MODE_OFS, 8'h24);
    $display("test reset done");
    wr_reg(`FFC_FOLD_OFS, 8'ha5);
    chk("fold ports", 8'ha5, {m2c, m1c});
    rd_reg(`FFC_FOLD_OFS, 8'ha5);
    for (int k = 0; k < 4; k++) begin
      v = {k[0], k[1], k[0], k[1:0], k[1:0], k[1]};
      wr_reg(`FFC_MODE_OFS, v);
      chk("mode ports", v, {dyn, flo, pol, indicator_led_output, ilim, ilen});
      rd_reg(`FFC_MODE_OFS, v);
    end
    wr_reg(`FFC_FAULT_OFS, 8'hff);
    rd_reg(`FFC_FAULT_OFS, 8'h00);
    rd_reg(8'h09, 8'h00);
    $display("test registers done");
    // Each event alone, so a swapped bit position shows up
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i);
      rd_reg(`FFC_FAULT_OFS, (i >= 3) ? (8'h01 << (i + 1)) : (8'h01 << i));
    end
    wr_reg(`FFC_MODE_OFS, 8'h24);
    pulse(7'h01);
    rd_reg(`FFC_FAULT_OFS, 8'h00);
    $display("test faults done");
    p2m <= 1'b1;
    fms <= 1'b1;
    oe <= 1'b1;
    host_u.wt(8);
    chk("flash", 8'h01, {7'h00, fa});
    tm1 <= 1'b1;
    gp2 <= 1'b1;
    host_u.wt(8);
    chk("mask active", 8'h03, {6'h00, m1a, m2a});
    tm1 <= 1'b0;
    gp2 <= 1'b0;
    rd_reg(`FFC_FAULT_OFS, 8'h0c);
    rd_reg(`FFC_FAULT_OFS, 8'h0c);
    oe <= 1'b0;
    host_u.wt(8);
    chk("flash", 8'h00, {7'h00, fa});
    oe <= 1'b1;
    host_u.wt(8);
    rd_reg(`FFC_FAULT_OFS, 8'h00);
    hw <= 1'b1;
    host_u.wt(8);
    chk("flash", 8'h00, {7'h00, fa});
    strobe_pin <= 1'b1;
    host_u.wt(8);
    chk("flash", 8'h01, {7'h00, fa});
    wr_reg(`FFC_MODE_OFS, 8'h04);
    chk("flash", 8'h00, {7'h00, fa});
    strobe_pin <= 1'b0;
    host_u.wt(8);
    chk("flash", 8'h01, {7'h00, fa});
    fms <= 1'b0;
    host_u.wt(8);
    chk("flash", 8'h00, {7'h00, fa});
    $display("test flash done");
    test_done();
  end
endmodule
